// *** hw/io_cond_pkg.sv ***
// Shared constants, types and register map for the filtered I/O block.
// Assumes a single 100 MHz clock and a Wishbone classic register bus.
package io_cond_pkg;

    // ********************************
    // Clock and timing
    // ********************************
    localparam int CLK_FREQ_HZ    = 100_000_000;
    localparam int TICK_TIME_US   = 1000;                              // Filter sample period
    localparam int TICK_CYCLES    = CLK_FREQ_HZ / 1_000_000 * TICK_TIME_US;
    localparam int TICK_CNT_W     = 17;                                // Holds TICK_CYCLES - 1

    // ********************************
    // Filter length in ticks
    // ********************************
    localparam int         FILT_LEN_W   = 6;
    localparam logic [5:0] FILT_MIN_LEN = 6'h01;                       // 1 ms, no bypass
    localparam logic [5:0] FILT_MAX_LEN = 6'h32;                       // 50 ms
    localparam logic [5:0] FILT_LEN_RST = 6'h01;

    // ********************************
    // Register map (byte addresses)
    // ********************************
    localparam int         ADDR_W         = 5;
    localparam logic [4:0] REG_CTRL_OFS   = 5'h00;
    localparam logic [4:0] REG_INCFG_OFS  = 5'h04;
    localparam logic [4:0] REG_OUTCFG_OFS = 5'h08;
    localparam logic [4:0] REG_OUTCMD_OFS = 5'h0c;
    localparam logic [4:0] REG_STATUS_OFS = 5'h10;

    // Field positions
    localparam int CTRL_EN_BIT     = 0;
    localparam int INCFG_LEN_LSB   = 0;
    localparam int INCFG_LOW_BIT   = 8;
    localparam int OUTCFG_POL_LSB  = 8;
    localparam int STATUS_OUT_LSB  = 4;
    localparam int STATUS_ALM_BIT  = 8;

    // Decoded register select
    typedef enum logic [2:0] {
        SEL_NONE   = 3'b000,
        SEL_CTRL   = 3'b001,
        SEL_INCFG  = 3'b010,
        SEL_OUTCFG = 3'b011,
        SEL_OUTCMD = 3'b100,
        SEL_STATUS = 3'b101
    } reg_sel_type;

    // Output function choices for the three general outputs
    typedef enum logic [1:0] {
        FUNC_USER  = 2'b00,
        FUNC_READY = 2'b01,
        FUNC_INPUT = 2'b10,
        FUNC_ALARM = 2'b11
    } out_func_type;

    // Per-input filter state
    typedef struct packed {
        logic                  level;
        logic [FILT_LEN_W-1:0] count;
    } filt_state_type;

    // Whole state of the top module
    typedef struct packed {
        logic                  ack;
        logic [31:0]           rdata;
        logic                  enable;
        logic                  in_low;
        logic [FILT_LEN_W-1:0] filt_len;
        logic [2:0][1:0]       func;
        logic [2:0]            pol;
        logic [2:0]            user_cond;
        logic [TICK_CNT_W-1:0] tick_cnt;
        logic                  tick;
        logic [3:0]            in_asserted;
        logic [3:0]            out_on;
        logic [3:0]            pin_level;
    } top_state_type;

endpackage

// *** hw/debounce_filter.sv ***
// One input debounce filter sampled on the millisecond tick.
// Assumes the raw input is synchronous to clk and len stays within 1..50.
`timescale 1ns/1ps
module debounce_filter
    import io_cond_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  ce,
    // Sample strobe and length
    input  wire logic                  tick,
    input  wire logic [FILT_LEN_W-1:0] len,
    // Input and filtered level
    input  wire logic                  raw,
    output logic                       level
);

    filt_state_type st_reg;
    filt_state_type st_next;

    // ********************************
    // Next state
    // ********************************
    // A differing sample must repeat len ticks in a row to be taken
    always_comb begin
        st_next = st_reg;
        if (tick) begin
            if (raw == st_reg.level) begin
                st_next.count = '0;
            end else if (st_reg.count + FILT_LEN_W'(1) >= len) begin
                st_next.level = raw;
                st_next.count = '0;
            end else begin
                st_next.count = st_reg.count + FILT_LEN_W'(1);
            end
        end
    end

    // Register, frozen while ce is low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.level;

    // ********************************
    // Checks
    // ********************************
    a_change_on_tick: assert property (@(posedge clk) disable iff (rst)
        (st_reg.level != $past(st_reg.level)) |-> $past(tick && ce))
        else $error("Filtered level moved without a tick");

    a_held_full_len: assert property (@(posedge clk) disable iff (rst)
        (st_reg.level != $past(st_reg.level)) |-> ($past(st_reg.count) + FILT_LEN_W'(1) >= $past(len)))
        else $error("Filtered level moved before the full filter time");

endmodule

// *** hw/filtered_io_conditioning.sv ***
// Input filtering and open-collector output control with a Wishbone slave.
// Assumes pins are synchronous to clk and a motor alarm level from the core.
`timescale 1ns/1ps
module filtered_io_conditioning
    import io_cond_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
    // Clock, reset, enable
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // Wishbone classic slave
    input  wire logic              wb_cyc,
    input  wire logic              wb_stb,
    input  wire logic              wb_we,
    input  wire logic [ADDR_W-1:0] wb_adr,
    input  wire logic [3:0]        wb_sel,
    input  wire logic [31:0]       wb_dat_w,
    output logic [31:0]            wb_dat_r,
    output logic                   wb_ack,
    // General inputs and alarm condition
    input  wire logic              general_input_a,
    input  wire logic              general_input_b,
    input  wire logic              general_input_c,
    input  wire logic              general_input_d,
    input  wire logic              alarm_active,
    // Open-collector outputs
    output logic                   general_output_a_out,
    output logic                   general_output_a_oe,
    output logic                   general_output_b_out,
    output logic                   general_output_b_oe,
    output logic                   general_output_c_out,
    output logic                   general_output_c_oe,
    output logic                   alarm_output_line_out,
    output logic                   alarm_output_line_oe
);

    // ********************************
    // Helper functions
    // ********************************
    // Address decode shared by the read and write paths
    function automatic reg_sel_type decode(input logic [ADDR_W-1:0] adr);
        case (adr)
            REG_CTRL_OFS:   decode = SEL_CTRL;
            REG_INCFG_OFS:  decode = SEL_INCFG;
            REG_OUTCFG_OFS: decode = SEL_OUTCFG;
            REG_OUTCMD_OFS: decode = SEL_OUTCMD;
            REG_STATUS_OFS: decode = SEL_STATUS;
            default:        decode = SEL_NONE;
        endcase
    endfunction

    // Out-of-range lengths are pulled back into 1..50
    function automatic logic [FILT_LEN_W-1:0] clamp_len(input logic [FILT_LEN_W-1:0] v);
        if (v < FILT_MIN_LEN) begin
            clamp_len = FILT_MIN_LEN;
        end else if (v > FILT_MAX_LEN) begin
            clamp_len = FILT_MAX_LEN;
        end else begin
            clamp_len = v;
        end
    endfunction

    top_state_type st_reg;
    top_state_type st_next;
    logic [3:0]    raw_in;
    logic [3:0]    stable;
    logic          req_hit;
    logic          wr_hit;
    reg_sel_type   sel;

    assign raw_in  = {general_input_d, general_input_c, general_input_b, general_input_a};
    assign req_hit = wb_cyc && wb_stb && !st_reg.ack;
    assign wr_hit  = req_hit && wb_we;
    assign sel     = decode(wb_adr);

    // ********************************
    // Input filters
    // ********************************
    // One filter per input, all sharing the tick and the length
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_filt
            debounce_filter u_filt (
                .clk   (clk),
                .rst   (rst),
                .ce    (ce),
                .tick  (st_reg.tick),
                .len   (st_reg.filt_len),
                .raw   (raw_in[gi]),
                .level (stable[gi])
            );
        end
    endgenerate

    // ********************************
    // Next state
    // ********************************
    always_comb begin
        logic       cond;
        logic       pol_eff;
        st_next = st_reg;
        cond    = 1'b0;
        pol_eff = 1'b0;

        // Millisecond tick, a single-cycle pulse
        if (st_reg.tick_cnt == TICK_CNT_W'(TICK_CYCLES_P - 1)) begin
            st_next.tick_cnt = '0;
            st_next.tick     = 1'b1;
        end else begin
            st_next.tick_cnt = st_reg.tick_cnt + TICK_CNT_W'(1);
            st_next.tick     = 1'b0;
        end

        // Bus answer one cycle after the request, dropped the cycle after
        st_next.ack = req_hit;

        // Register writes; unmapped writes are acknowledged and dropped
        if (wr_hit) begin
            case (sel)
                SEL_CTRL: begin
                    if (wb_sel[0]) begin
                        st_next.enable = wb_dat_w[CTRL_EN_BIT];
                    end
                end
                SEL_INCFG: begin
                    if (wb_sel[0]) begin
                        st_next.filt_len = clamp_len(wb_dat_w[INCFG_LEN_LSB +: FILT_LEN_W]);
                    end
                    if (wb_sel[1]) begin
                        st_next.in_low = wb_dat_w[INCFG_LOW_BIT];
                    end
                end
                SEL_OUTCFG: begin
                    if (wb_sel[0]) begin
                        st_next.func = wb_dat_w[5:0];
                    end
                    if (wb_sel[1]) begin
                        st_next.pol = wb_dat_w[OUTCFG_POL_LSB +: 3];
                    end
                end
                SEL_OUTCMD: begin
                    if (wb_sel[0]) begin
                        st_next.user_cond = wb_dat_w[2:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Read data, unmapped and reserved bits read as zero
        if (req_hit && !wb_we) begin
            case (sel)
                SEL_CTRL:   st_next.rdata = 32'(st_reg.enable);
                SEL_INCFG:  st_next.rdata = {23'h0, st_reg.in_low, 2'h0, st_reg.filt_len};
                SEL_OUTCFG: st_next.rdata = {21'h0, st_reg.pol, 2'h0, st_reg.func};
                SEL_OUTCMD: st_next.rdata = {29'h0, st_reg.user_cond};
                SEL_STATUS: st_next.rdata = {23'h0, alarm_active, st_reg.out_on, st_reg.in_asserted};
                default:    st_next.rdata = 32'h0;
            endcase
        end else begin
            st_next.rdata = 32'h0;
        end

        // Filtered inputs with polarity, quiet until enabled
        if (st_reg.enable) begin
            st_next.in_asserted = stable ^ {4{st_reg.in_low}};
        end else begin
            st_next.in_asserted = 4'h0;
        end

        // General outputs; polarity only counts in user-defined mode
        for (int i = 0; i < 3; i++) begin
            case (out_func_type'(st_reg.func[i]))
                FUNC_USER:  cond = st_reg.user_cond[i];
                FUNC_READY: cond = 1'b1;
                FUNC_INPUT: cond = st_reg.in_asserted[i];
                FUNC_ALARM: cond = alarm_active;
                default:    cond = 1'b0;
            endcase
            pol_eff = (st_reg.func[i] == FUNC_USER) && st_reg.pol[i];
            st_next.out_on[i] = st_reg.enable && (cond ^ pol_eff);
        end

        // Alarm line fixed active low: conducts while no alarm
        st_next.out_on[3] = st_reg.enable && !alarm_active;

        // Open-collector pins only ever pull low
        // Never driving high means a shorted line cannot fight the pull-up
        st_next.pin_level = 4'h0;
    end

    // ********************************
    // State register
    // ********************************
    // Everything freezes while ce is low, bus answers included
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg          <= '0;
            st_reg.filt_len <= FILT_LEN_RST;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // ********************************
    // Outputs, straight from the state register
    // ********************************
    assign wb_dat_r              = st_reg.rdata;
    assign wb_ack                = st_reg.ack;
    assign general_output_a_out  = st_reg.pin_level[0];
    assign general_output_a_oe   = st_reg.out_on[0];
    assign general_output_b_out  = st_reg.pin_level[1];
    assign general_output_b_oe   = st_reg.out_on[1];
    assign general_output_c_out  = st_reg.pin_level[2];
    assign general_output_c_oe   = st_reg.out_on[2];
    assign alarm_output_line_out = st_reg.pin_level[3];
    assign alarm_output_line_oe  = st_reg.out_on[3];

    // ********************************
    // Checks
    // ********************************
    a_len_in_range: assert property (@(posedge clk) disable iff (rst)
        (st_reg.filt_len >= FILT_MIN_LEN) && (st_reg.filt_len <= FILT_MAX_LEN))
        else $error("Filter length outside 1 to 50");

    a_len_floor: assert property (@(posedge clk) disable iff (rst)
        ce && wr_hit && (sel == SEL_INCFG) && wb_sel[0] && (wb_dat_w[5:0] == 6'h00)
        |=> (st_reg.filt_len == FILT_MIN_LEN))
        else $error("Zero filter length was not raised to one");

    a_in_polarity: assert property (@(posedge clk) disable iff (rst)
        ce && st_reg.enable
        |=> (st_reg.in_asserted == ($past(stable) ^ {4{$past(st_reg.in_low)}})))
        else $error("Input polarity not applied");

    a_quiet_idle: assert property (@(posedge clk) disable iff (rst)
        ce && !st_reg.enable |=> (st_reg.in_asserted == 4'h0) && (st_reg.out_on == 4'h0))
        else $error("Activity before configuration applied");

    a_alarm_low_on: assert property (@(posedge clk) disable iff (rst)
        ce && st_reg.enable && !alarm_active |=> alarm_output_line_oe)
        else $error("Alarm line not conducting without alarm");

    a_alarm_low_off: assert property (@(posedge clk) disable iff (rst)
        ce && alarm_active |=> !alarm_output_line_oe)
        else $error("Alarm line conducting during alarm");

    a_fixed_pol: assert property (@(posedge clk) disable iff (rst)
        ce && st_reg.enable && (st_reg.func[0] == FUNC_READY) |=> general_output_a_oe)
        else $error("Polarity applied outside user-defined mode");

    a_user_low: assert property (@(posedge clk) disable iff (rst)
        ce && st_reg.enable && (st_reg.func[1] == FUNC_USER) && st_reg.pol[1] && !st_reg.user_cond[1]
        |=> general_output_b_oe ##0 (general_output_b_out == 1'b0))
        else $error("Active-low user output not conducting on false");

    a_tick_pulse: assert property (@(posedge clk) disable iff (rst)
        ce && st_reg.tick |=> !st_reg.tick)
        else $error("Tick longer than one cycle");

    a_ack_single: assert property (@(posedge clk) disable iff (rst)
        ce && wb_ack |=> !wb_ack)
        else $error("Ack held for more than one cycle");

    // Bus answer, length ceiling, user-defined polarity and the fixed-polarity input and alarm output functions
    a_ack_answer: assert property (@(posedge clk) disable iff (rst)
        ce && req_hit |=> wb_ack)
        else $error("Bus request not answered in one cycle");

    a_len_ceiling: assert property (@(posedge clk) disable iff (rst)
        ce && wr_hit && (sel == SEL_INCFG) && wb_sel[0] && (wb_dat_w[5:0] > FILT_MAX_LEN)
        |=> (st_reg.filt_len == FILT_MAX_LEN))
        else $error("Long filter length was not cut to fifty");

    a_user_pol: assert property (@(posedge clk) disable iff (rst)
        ce && st_reg.enable && (st_reg.func[2] == FUNC_USER)
        |=> (general_output_c_oe == ($past(st_reg.user_cond[2]) ^ $past(st_reg.pol[2]))))
        else $error("User output ignores its polarity");

    a_input_nopol: assert property (@(posedge clk) disable iff (rst)
        ce && st_reg.enable && (st_reg.func[1] == FUNC_INPUT)
        |=> (general_output_b_oe == $past(st_reg.in_asserted[1])))
        else $error("Input echo output took a polarity");

    a_alarm_copy: assert property (@(posedge clk) disable iff (rst)
        ce && st_reg.enable && (st_reg.func[2] == FUNC_ALARM)
        |=> (general_output_c_oe == $past(alarm_active)))
        else $error("Alarm copy output took a polarity");

endmodule

// *** dv/plc_model.sv ***
// Model of the controller wired to the four inputs and four outputs.
// Assumes pull-ups on the open-collector lines at the controller side.
`timescale 1ns/1ps
module plc_model (
    // Clock
    input  wire logic       clk,
    // Commanded input levels and driven lines
    input  wire logic [3:0] level_cmd,
    output logic [3:0]      raw_in,
    // Transistor enables and sensed line levels
    input  wire logic [3:0] oe,
    output logic [3:0]      line_sense
);
    // Inputs change just after the edge, like a synchronous driver
    always @(posedge clk) raw_in <= level_cmd;
    // Pull-up wins unless the transistor conducts
    assign line_sense = ~oe;
endmodule

// *** dv/filtered_io_conditioning_tb.sv ***
// Self-checking bench for the filtered I/O block.
// Assumes the plc_model partner and a shortened tick period.
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
    $display("wrong value at %0t: got %h exp %h", $time, (got), (exp)); end end
module filtered_io_conditioning_tb;
    import io_cond_pkg::*;
    localparam int TICK_SIM = 10;
    logic        clk, rst, cyc, stb, we, alarm;
    logic [4:0]  adr;
    logic [31:0] dw, rd;
    wire  [31:0] dr;
    wire         ack;
    logic [3:0]  cmd, v, e;
    wire  [3:0]  raw, oe, outs, sense;
    logic [5:0]  f;
    logic [2:0]  p, u;
    int          seed, mismatches, tests_run, cycles, len;

    // Short tick keeps the millisecond counts affordable
    filtered_io_conditioning #(.TICK_CYCLES_P(TICK_SIM)) dut_u (
        .clk(clk), .rst(rst), .ce(1'b1),
        .wb_cyc(cyc), .wb_stb(stb), .wb_we(we), .wb_adr(adr), .wb_sel(4'hf),
        .wb_dat_w(dw), .wb_dat_r(dr), .wb_ack(ack),
        .general_input_a(raw[0]), .general_input_b(raw[1]),
        .general_input_c(raw[2]), .general_input_d(raw[3]), .alarm_active(alarm),
        .general_output_a_out(outs[0]), .general_output_a_oe(oe[0]),
        .general_output_b_out(outs[1]), .general_output_b_oe(oe[1]),
        .general_output_c_out(outs[2]), .general_output_c_oe(oe[2]),
        .alarm_output_line_out(outs[3]), .alarm_output_line_oe(oe[3]));

    plc_model partner_u (.clk(clk), .level_cmd(cmd), .raw_in(raw), .oe(oe), .line_sense(sense));

    // ****************************************
    // Clock, timeout and bus tasks
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Cuts a hang short; the whole run needs a few hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Classic cycle; held until ack is sampled, then released
    // Only the global cycle ceiling ends a wait for ack
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dw  <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // Expected transistor enables; alarm line is inverted
    function automatic logic [3:0] exp_oe(input logic [5:0] fn, input logic [2:0] pol,
                                          input logic [2:0] usr, input logic [3:0] asr,
                                          input logic al);
        logic [3:0] r;
        for (int k = 0; k < 3; k++) begin
            case (fn[2*k +: 2])
                2'h0: r[k] = usr[k] ^ pol[k];
                2'h1: r[k] = 1'b1;
                2'h2: r[k] = asr[k];
                default: r[k] = al;
            endcase
        end
        r[3] = ~al;
        return r;
    endfunction

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        seed = 93072;
        mismatches = 0;
        tests_run = 0;
        cycles = 0;
        rst = 1'b1;
        {cyc, stb, we, alarm} = 4'h0;
        adr = 5'h00;
        dw = 32'h0;
        cmd = 4'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // Before enable: inputs and conditions high, nothing reported
        cmd <= 4'hf;
        bus(1'b1, REG_OUTCMD_OFS, 32'h7);
        repeat (5 * TICK_SIM) @(posedge clk);
        bus(1'b0, REG_STATUS_OFS, 32'h0);
        `CHK(rd[7:0], 8'h00)
        `CHK(oe, 4'h0)
        `CHK(outs, 4'h0)
        bus(1'b0, REG_INCFG_OFS, 32'h0);
        `CHK(rd[8:0], 9'h001)
        // Length limits: zero becomes one, too long becomes fifty
        bus(1'b1, REG_INCFG_OFS, 32'h0);
        bus(1'b0, REG_INCFG_OFS, 32'h0);
        `CHK(rd[5:0], FILT_MIN_LEN)
        bus(1'b1, REG_INCFG_OFS, 32'h3f);
        bus(1'b0, REG_INCFG_OFS, 32'h0);
        `CHK(rd[5:0], FILT_MAX_LEN)
        bus(1'b0, 5'h14, 32'h0);
        `CHK(rd, 32'h0)
        // Short pulse dropped, long level accepted
        cmd <= 4'h0;
        len = 2 + ($unsigned($random(seed)) % 7);
        v = 4'($random(seed)) | 4'h1;
        bus(1'b1, REG_CTRL_OFS, 32'h1);
        bus(1'b1, REG_INCFG_OFS, 32'(len));
        repeat ((len + 2) * TICK_SIM) @(posedge clk);
        cmd <= v;
        repeat ((len - 1) * TICK_SIM) @(posedge clk);
        cmd <= 4'h0;
        repeat ((len + 2) * TICK_SIM) @(posedge clk);
        bus(1'b0, REG_STATUS_OFS, 32'h0);
        `CHK(rd[3:0], 4'h0)
        cmd <= v;
        repeat ((len + 1) * TICK_SIM + 3) @(posedge clk);
        bus(1'b0, REG_STATUS_OFS, 32'h0);
        `CHK(rd[3:0], v)
        `CHK(rd[7:4], exp_oe(6'h00, 3'h0, 3'h7, v, 1'b0))
        // Active-low reading of the same stable levels
        bus(1'b1, REG_INCFG_OFS, 32'h100 | 32'(len));
        repeat (3) @(posedge clk);
        bus(1'b0, REG_STATUS_OFS, 32'h0);
        `CHK(rd[3:0], ~v)
        // Every output function, random polarity and conditions
        for (int i = 0; i < 8; i++) begin
            f = {2'((i + 2) % 4), 2'((i + 1) % 4), 2'(i % 4)};
            p = 3'($random(seed));
            u = 3'($random(seed));
            // Corner: output b user-defined, active low, condition false
            if (i == 3) begin
                p = 3'h7;
                u = 3'h0;
            end
            bus(1'b1, REG_OUTCFG_OFS, {21'h0, p, 2'h0, f});
            bus(1'b1, REG_OUTCMD_OFS, {29'h0, u});
            alarm <= 1'($random(seed));
            repeat (4) @(posedge clk);
            e = exp_oe(f, p, u, ~v, alarm);
            `CHK(oe[2:0], e[2:0])
            `CHK(oe[3], ~alarm)
            `CHK(sense, ~e)
            `CHK(outs, 4'h0)
            bus(1'b0, REG_STATUS_OFS, 32'h0);
            `CHK(rd[8:4], {alarm, e})
        end
        tally_and_finish();
    end
endmodule
